// ---- atsl_cfg.svh ----
`ifndef ATSL_CFG_SVH
`define ATSL_CFG_SVH

// Clock period and the millisecond time base.
`define ATSL_CLK_PERIOD_NS 50
`define ATSL_TICK_NS 1000000
`define ATSL_TICK_CYCLES (`ATSL_TICK_NS / `ATSL_CLK_PERIOD_NS)

// Teach-in and inhibit times, in milliseconds.
`define ATSL_TEACH_SETTLE_MS 10000
`define ATSL_POWEROFF_WAIT_MS 300000
`define ATSL_INHIBIT_MS 600000

// Flash timing in milliseconds.
`define ATSL_SLOW_PERIOD_MS 1000
`define ATSL_SLOW_ON_MS 500
`define ATSL_FAST_PERIOD_MS 333
`define ATSL_FAST_ON_MS 60
`define ATSL_PULSE_SLOT_MS 400
`define ATSL_PULSE_ON_MS 200
`define ATSL_PAUSE_SLOTS 3

// Red flash counts per error cause.
`define ATSL_CODE_NONE 3'h0
`define ATSL_CODE_OUT_ONE 3'h1
`define ATSL_CODE_OUT_TWO 3'h2
`define ATSL_CODE_CROSS 3'h3
`define ATSL_CODE_TEMP 3'h4
`define ATSL_CODE_ACTUATOR 3'h5
`define ATSL_CODE_DISCREP 3'h6

// Bit positions of the synchronised pin vector.
`define ATSL_PIN_W 13
`define ATSL_PIN_ACT 0
`define ATSL_PIN_NEWCODE 1
`define ATSL_PIN_MARGIN 2
`define ATSL_PIN_IN_ONE 3
`define ATSL_PIN_IN_TWO 4
`define ATSL_PIN_ERR_ONE 5
`define ATSL_PIN_ERR_TWO 6
`define ATSL_PIN_CROSS 7
`define ATSL_PIN_TEMP 8
`define ATSL_PIN_DISCREP 9
`define ATSL_PIN_INTERNAL 10
`define ATSL_PIN_CODED 11
`define ATSL_PIN_ONETIME 12

`endif

// ---- atsl_pkg.sv ----
package atsl_pkg;

  // Teach-in and run states, one-hot.
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_TEACH = 5'h02,
    ST_PWROFF = 5'h04,
    ST_FAIL = 5'h08,
    ST_INHIBIT = 5'h10
  } atsl_state_e;

endpackage : atsl_pkg

// ---- atsl_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module atsl_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] synced
);

  logic [W-1:0] meta_q;

  // Two flops per bit; only the second stage is seen by any logic.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      synced <= '0;
    end
    else
    begin
      meta_q <= pin;
      synced <= meta_q;
    end
  end

endmodule : atsl_sync

`default_nettype wire

// ---- atsl_core.sv ----
// Notes on behaviour
// - During teach-in with actuator present, red LED steady, yellow flashes at 1 Hz.
// - After 10 s of teach-in, yellow gives brief 3 Hz flashes asking power-off.
// - No power-off within 5 minutes aborts teach-in and flashes red five times.
// - After power returns, new code is committed only on second actuator detection.
// - Standard-coded sensors accept their actuator directly, with no teach-in.
// - One-time variant locks first pairing and refuses every later teach-in.
// - Repeatable variant teaches any number of times; new code replaces old.
// - Repeatable variant keeps safety outputs inhibited ten minutes after teaching.
// - Green flashes during inhibit until time expired and new actuator detected.
// - Actuator leaving active zone disables both safety outputs at once.
// - Green LED steady when powered, both safety inputs present and no error, internal fault, teach-in or inhibit.
// - Green LED flashes at 1 Hz when either or both safety inputs missing.
// - Yellow LED on whenever a valid actuator is in sensing range with no error, internal fault or inhibit.
// - Yellow LED flashes instead while actuator sits in marginal limit area.
// - Red LED is active whenever an error condition is detected.
// - Red pulse count gives cause: 1..6 for output, cross, temp, actuator, discrepancy.
// - Red steady with yellow flash when teaching; red steady for internal fault.
// - LED indications are the same for either diagnostic output style.
`timescale 1ns/1ps
`default_nettype none
`include "atsl_cfg.svh"

module atsl_core #(
  parameter int TICK_CYCLES = `ATSL_TICK_CYCLES,
  parameter int TEACH_SETTLE_MS = `ATSL_TEACH_SETTLE_MS,
  parameter int POWEROFF_WAIT_MS = `ATSL_POWEROFF_WAIT_MS,
  parameter int INHIBIT_MS = `ATSL_INHIBIT_MS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic actuator_present,
  input wire logic actuator_new_code,
  input wire logic actuator_margin,
  input wire logic safety_input_one,
  input wire logic safety_input_two,
  input wire logic fault_output_one,
  input wire logic fault_output_two,
  input wire logic fault_cross_wire,
  input wire logic fault_over_temp,
  input wire logic fault_discrepancy,
  input wire logic fault_internal,
  input wire logic individually_coded,
  input wire logic one_time_pairing_variant,
  input wire logic nv_code_pending,
  input wire logic nv_pairing_locked,
  output logic nv_store_pending,
  output logic nv_commit,
  output logic nv_discard,
  output logic safety_output_one,
  output logic safety_output_two,
  output logic led_green,
  output logic led_yellow,
  output logic led_red
);

  logic [`ATSL_PIN_W-1:0] pins_s;
  logic act_s, new_s, margin_s, in_one_s, in_two_s, internal_s, coded_s, onetime_s;
  logic pend_s, locked_s, tick, slow_on, fast_on, timer_hit, red_pulse;
  logic enable_q, inputs_ok, start_teach, commit_now;
  logic [1:0] nv_s;
  logic [14:0] tick_cnt_q;
  logic [9:0] slow_ms_q;
  logic [8:0] fast_ms_q, slot_ms_q;
  logic [19:0] timer_ms_q, timer_limit;
  logic [2:0] err_code, shown_code_q;
  logic [3:0] slot_idx_q;
  atsl_pkg::atsl_state_e state_q, state_d;

  // Every pin crosses two flops before use.
  atsl_sync #(.W(`ATSL_PIN_W)) u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin({one_time_pairing_variant, individually_coded, fault_internal, fault_discrepancy,
          fault_over_temp, fault_cross_wire, fault_output_two, fault_output_one,
          safety_input_two, safety_input_one, actuator_margin, actuator_new_code,
          actuator_present}),
    .synced(pins_s)
  );

  // The stored-code status comes from the memory outside, also asynchronous.
  atsl_sync #(.W(2)) u_nv_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin({nv_pairing_locked, nv_code_pending}),
    .synced(nv_s)
  );

  assign act_s = pins_s[`ATSL_PIN_ACT];
  assign new_s = pins_s[`ATSL_PIN_NEWCODE];
  assign margin_s = pins_s[`ATSL_PIN_MARGIN];
  assign in_one_s = pins_s[`ATSL_PIN_IN_ONE];
  assign in_two_s = pins_s[`ATSL_PIN_IN_TWO];
  assign internal_s = pins_s[`ATSL_PIN_INTERNAL];
  assign coded_s = pins_s[`ATSL_PIN_CODED];
  assign onetime_s = pins_s[`ATSL_PIN_ONETIME];
  assign pend_s = nv_s[0];
  assign locked_s = nv_s[1];
  assign inputs_ok = in_one_s && in_two_s;

  // single time base
  // One millisecond tick feeds every flash and timeout; reset restarts it.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      tick_cnt_q <= 15'h0000;
    else if (tick)
      tick_cnt_q <= 15'h0000;
    else
      tick_cnt_q <= tick_cnt_q + 15'h0001;
  end
  assign tick = (tick_cnt_q == 15'(TICK_CYCLES - 1));

  // Free-running slow (1 Hz) and fast (3 Hz) flash phases.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slow_ms_q <= 10'h000;
      fast_ms_q <= 9'h000;
    end
    else if (tick)
    begin
      slow_ms_q <= (slow_ms_q == 10'(`ATSL_SLOW_PERIOD_MS - 1)) ? 10'h000 : slow_ms_q + 10'h001;
      fast_ms_q <= (fast_ms_q == 9'(`ATSL_FAST_PERIOD_MS - 1)) ? 9'h000 : fast_ms_q + 9'h001;
    end
  end
  assign slow_on = (slow_ms_q < 10'(`ATSL_SLOW_ON_MS));
  // The fast flash is a short blip so it reads as distinct from the 1 Hz blink.
  assign fast_on = (fast_ms_q < 9'(`ATSL_FAST_ON_MS));

  // one-time lock
  // A fresh code starts teach-in only on coded sensors; on the one-time variant only if not already locked.
  assign start_teach = coded_s && new_s && !pend_s && !(onetime_s && locked_s);

  // second detection commit
  // A pending code is made live only when the actuator is seen again after power-up.
  assign commit_now = coded_s && pend_s && new_s && !(onetime_s && locked_s);

  // Millisecond timer per state; restarts on every state change.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      timer_ms_q <= 20'h00000;
    else if (state_d != state_q)
      timer_ms_q <= 20'h00000;
    else if (tick && !timer_hit)
      timer_ms_q <= timer_ms_q + 20'h00001;
  end

  always_comb
  begin
    case (state_q)
      atsl_pkg::ST_TEACH: timer_limit = 20'(TEACH_SETTLE_MS - 1);
      atsl_pkg::ST_PWROFF: timer_limit = 20'(POWEROFF_WAIT_MS - 1);
      atsl_pkg::ST_INHIBIT: timer_limit = 20'(INHIBIT_MS); // Release needs the full span.
      default: timer_limit = 20'hFFFFF;
    endcase
  end
  assign timer_hit = (timer_ms_q >= timer_limit);

  // Teach-in sequencer.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      atsl_pkg::ST_RUN:
      begin
        if (commit_now && !onetime_s)
          state_d = atsl_pkg::ST_INHIBIT;
        else if (start_teach)
          state_d = atsl_pkg::ST_TEACH;
      end
      atsl_pkg::ST_TEACH:
      begin
        if (!new_s)
          state_d = atsl_pkg::ST_RUN;
        else if (tick && timer_hit)
          state_d = atsl_pkg::ST_PWROFF;
      end
      atsl_pkg::ST_PWROFF:
      begin
        if (tick && timer_hit)
          state_d = atsl_pkg::ST_FAIL;
      end
      // Fail stays until power cycles; reset is the only way out.
      atsl_pkg::ST_FAIL: state_d = atsl_pkg::ST_FAIL;
      atsl_pkg::ST_INHIBIT:
      begin
        if (timer_hit && act_s)
          state_d = atsl_pkg::ST_RUN;
      end
      default: state_d = atsl_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= atsl_pkg::ST_RUN;
    else
      state_q <= state_d;
  end

  // Memory strobes: store on power-off request, commit on second detection, drop on abort.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      nv_store_pending <= 1'b0;
      nv_commit <= 1'b0;
      nv_discard <= 1'b0;
    end
    else
    begin
      nv_store_pending <= (state_q == atsl_pkg::ST_TEACH) && (state_d == atsl_pkg::ST_PWROFF);
      nv_commit <= (state_q == atsl_pkg::ST_RUN) && commit_now;
      nv_discard <= (state_q == atsl_pkg::ST_PWROFF) && (state_d == atsl_pkg::ST_FAIL);
    end
  end

  // cause encoding
  // Lowest count wins when several causes are present together.
  always_comb
  begin
    if (pins_s[`ATSL_PIN_ERR_ONE])
      err_code = `ATSL_CODE_OUT_ONE;
    else if (pins_s[`ATSL_PIN_ERR_TWO])
      err_code = `ATSL_CODE_OUT_TWO;
    else if (pins_s[`ATSL_PIN_CROSS])
      err_code = `ATSL_CODE_CROSS;
    else if (pins_s[`ATSL_PIN_TEMP])
      err_code = `ATSL_CODE_TEMP;
    else if (state_q == atsl_pkg::ST_FAIL)
      err_code = `ATSL_CODE_ACTUATOR;
    else if (pins_s[`ATSL_PIN_DISCREP])
      err_code = `ATSL_CODE_DISCREP;
    else
      err_code = `ATSL_CODE_NONE;
  end

  // grouped pulses
  // Slots of 400 ms, pulse in the first half; three empty slots form the pause.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shown_code_q <= `ATSL_CODE_NONE;
      slot_ms_q <= 9'h000;
      slot_idx_q <= 4'h0;
    end
    else if (err_code != shown_code_q)
    begin
      shown_code_q <= err_code;
      slot_ms_q <= 9'h000;
      slot_idx_q <= 4'h0;
    end
    else if (tick)
    begin
      if (slot_ms_q == 9'(`ATSL_PULSE_SLOT_MS - 1))
      begin
        slot_ms_q <= 9'h000;
        if (slot_idx_q == 4'({1'b0, shown_code_q} + 4'(`ATSL_PAUSE_SLOTS) - 4'h1))
          slot_idx_q <= 4'h0;
        else
          slot_idx_q <= slot_idx_q + 4'h1;
      end
      else
        slot_ms_q <= slot_ms_q + 9'h001;
    end
  end
  assign red_pulse = (slot_idx_q < {1'b0, shown_code_q}) &&
                     (slot_ms_q < 9'(`ATSL_PULSE_ON_MS));

  // Output enable: only in run with actuator, inputs and no error or internal fault.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      enable_q <= 1'b0;
    else
      enable_q <= (state_d == atsl_pkg::ST_RUN) && act_s && inputs_ok &&
                  (err_code == `ATSL_CODE_NONE) && !internal_s &&
                  !(coded_s && !locked_s && !pend_s && new_s);
  end

  // immediate disable
  // Gated by the live presence so removal cuts outputs without waiting a flop.
  assign safety_output_one = enable_q && act_s;
  assign safety_output_two = enable_q && act_s;

  // LED drivers; the same drive serves either diagnostic style.
  // common indication
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
    end
    else
    begin
      if (state_q == atsl_pkg::ST_INHIBIT || !inputs_ok)
        led_green <= slow_on;
      else
        led_green <= (err_code == `ATSL_CODE_NONE) && !internal_s &&
                     !(state_q == atsl_pkg::ST_TEACH) && !(state_q == atsl_pkg::ST_PWROFF);
      if (state_q == atsl_pkg::ST_PWROFF)
        led_yellow <= fast_on;
      else if (state_q == atsl_pkg::ST_TEACH)
        led_yellow <= slow_on;
      else if (state_q == atsl_pkg::ST_INHIBIT || err_code != `ATSL_CODE_NONE || internal_s)
        led_yellow <= 1'b0;
      else if (act_s && margin_s)
        led_yellow <= slow_on;
      else
        led_yellow <= act_s;
      if (state_q == atsl_pkg::ST_TEACH || state_q == atsl_pkg::ST_PWROFF || internal_s)
        led_red <= 1'b1;
      else
        led_red <= red_pulse;
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  outs_follow_act_a: assert property (!act_s |-> !safety_output_one && !safety_output_two)
    else $error("Safety output active without actuator.");
  teach_red_a: assert property (state_q == atsl_pkg::ST_TEACH ##1 state_q == atsl_pkg::ST_TEACH
    |-> led_red)
    else $error("Red not steady during teach-in.");
  teach_yellow_a: assert property (state_q == atsl_pkg::ST_TEACH |=> led_yellow == $past(slow_on))
    else $error("Yellow not at slow flash during teach-in.");
  settle_end_a: assert property (state_q == atsl_pkg::ST_TEACH && new_s && tick && timer_hit
    |=> state_q == atsl_pkg::ST_PWROFF && nv_store_pending)
    else $error("Teach-in did not move to power-off request.");
  abort_five_a: assert property (state_q == atsl_pkg::ST_PWROFF && tick && timer_hit
    |=> state_q == atsl_pkg::ST_FAIL && nv_discard ##1 shown_code_q == `ATSL_CODE_ACTUATOR
    || $past(err_code) < `ATSL_CODE_ACTUATOR)
    else $error("Power-off timeout did not abort with five pulses.");
  commit_cause_a: assert property (nv_commit |-> $past(new_s && pend_s && coded_s))
    else $error("Code committed without second detection.");
  onetime_lock_a: assert property (onetime_s && locked_s && state_q == atsl_pkg::ST_RUN
    |=> state_q != atsl_pkg::ST_TEACH)
    else $error("Locked pairing entered teach-in.");
  inhibit_entry_a: assert property (nv_commit && !$past(onetime_s)
    |-> state_q == atsl_pkg::ST_INHIBIT)
    else $error("Repeatable commit without inhibit.");
  inhibit_outs_a: assert property (state_q == atsl_pkg::ST_INHIBIT
    |-> !safety_output_one && !safety_output_two)
    else $error("Output enabled during inhibit.");
  inputs_flash_a: assert property (!inputs_ok |=> led_green == $past(slow_on))
    else $error("Green not flashing with input missing.");
  red_internal_a: assert property (internal_s |=> led_red)
    else $error("Red not steady on internal fault.");

  teach_seen_c: cover property (state_q == atsl_pkg::ST_TEACH ##1 state_q == atsl_pkg::ST_PWROFF);
  abort_seen_c: cover property (state_q == atsl_pkg::ST_FAIL);
  inhibit_seen_c: cover property (state_q == atsl_pkg::ST_INHIBIT ##1 state_q == atsl_pkg::ST_RUN);
  enable_seen_c: cover property (safety_output_one ##1 !safety_output_one);

endmodule : atsl_core

`default_nettype wire

// ---- atsl_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

// Coded actuator and non-volatile code store facing the core.
// Position 0 is away, 1 is the marginal limit area, 2 is full range.
module atsl_partner (
  input wire logic core_clk,
  input wire logic individually_coded,
  input wire logic [1:0] act_pos,
  input wire logic [3:0] act_id,
  input wire logic nv_store_pending,
  input wire logic nv_commit,
  input wire logic nv_discard,
  output logic actuator_present,
  output logic actuator_new_code,
  output logic actuator_margin,
  output var logic nv_code_pending,
  output var logic nv_pairing_locked
);
  logic [3:0] live_q;
  logic [3:0] pend_q;
  logic match;

  // The store survives power cycles, so it starts once and ignores rstn.
  // It comes from the factory already paired, to show repeat teaching.
  initial
  begin
    live_q = 4'h1;
    pend_q = 4'h0;
    nv_code_pending = 1'b0;
    nv_pairing_locked = 1'b1;
  end

  assign match = !individually_coded || (act_id == live_q);
  assign actuator_present = (act_pos != 2'h0) && match;
  assign actuator_new_code = (act_pos != 2'h0) && !match;
  assign actuator_margin = (act_pos == 2'h1);

  always @(posedge core_clk)
  begin
    if (nv_store_pending)
    begin
      pend_q <= act_id;
      nv_code_pending <= 1'b1;
    end
    if (nv_commit)
    begin
      live_q <= pend_q;
      nv_code_pending <= 1'b0;
      nv_pairing_locked <= 1'b1;
    end
    if (nv_discard)
      nv_code_pending <= 1'b0;
  end
endmodule : atsl_partner
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "atsl_cfg.svh"

module tb_top;
  // Shortened time base: one millisecond is four clocks.
  localparam int TK = 4;
  localparam int SETTLE = 650;
  localparam int WAITP = 400;
  localparam int INHIB = 700;
  localparam int WIN = 2400;

  typedef struct packed {
    logic coded;
    logic [1:0] pos;
    logic [3:0] id;
    logic [1:0] inp;
    logic [5:0] flt;
    logic so;
    logic [1:0] eg;
    logic [1:0] ey;
    logic [1:0] er;
  } atsl_row_s;

  // LED classes: 0 off, 1 steady, 2 flashing.
  atsl_row_s rows [7] = '{
    '{1'b1, 2'h2, 4'h1, 2'h3, 6'h00, 1'b1, 2'h1, 2'h1, 2'h0},
    '{1'b1, 2'h1, 4'h1, 2'h3, 6'h00, 1'b1, 2'h1, 2'h2, 2'h0},
    '{1'b1, 2'h0, 4'h1, 2'h3, 6'h00, 1'b0, 2'h1, 2'h0, 2'h0},
    '{1'b1, 2'h2, 4'h1, 2'h2, 6'h00, 1'b0, 2'h2, 2'h1, 2'h0},
    '{1'b1, 2'h2, 4'h1, 2'h0, 6'h00, 1'b0, 2'h2, 2'h1, 2'h0},
    '{1'b0, 2'h2, 4'h9, 2'h3, 6'h00, 1'b1, 2'h1, 2'h1, 2'h0},
    '{1'b1, 2'h2, 4'h1, 2'h3, 6'h20, 1'b0, 2'h0, 2'h0, 2'h1}};
  logic [5:0] cmask [5] = '{6'h01, 6'h02, 6'h14, 6'h08, 6'h10};
  int cnum [5] = '{1, 2, 3, 4, 6};

  logic core_clk, rstn, in_one, in_two, coded, onet;
  logic [5:0] flt;
  logic [1:0] pos;
  logic [3:0] aid;
  logic ap, an, am, cp, pl, st, cm, dc, so1, so2, g, y, r;
  int miscompares = 0;
  int check_count = 0;
  int n_st = 0;
  int n_cm = 0;
  int n_dc = 0;
  int hg, hy, hr, hs, pr, el;

  atsl_core #(.TICK_CYCLES(TK), .TEACH_SETTLE_MS(SETTLE), .POWEROFF_WAIT_MS(WAITP),
    .INHIBIT_MS(INHIB)) u_atsl_core (.core_clk(core_clk), .rstn(rstn),
    .actuator_present(ap), .actuator_new_code(an), .actuator_margin(am),
    .safety_input_one(in_one), .safety_input_two(in_two), .fault_output_one(flt[0]),
    .fault_output_two(flt[1]), .fault_cross_wire(flt[2]), .fault_over_temp(flt[3]),
    .fault_discrepancy(flt[4]), .fault_internal(flt[5]), .individually_coded(coded),
    .one_time_pairing_variant(onet), .nv_code_pending(cp), .nv_pairing_locked(pl),
    .nv_store_pending(st), .nv_commit(cm), .nv_discard(dc), .safety_output_one(so1),
    .safety_output_two(so2), .led_green(g), .led_yellow(y), .led_red(r));

  atsl_partner u_atsl_partner (.core_clk(core_clk), .individually_coded(coded),
    .act_pos(pos), .act_id(aid), .nv_store_pending(st), .nv_commit(cm),
    .nv_discard(dc), .actuator_present(ap), .actuator_new_code(an),
    .actuator_margin(am), .nv_code_pending(cp), .nv_pairing_locked(pl));

  // Free-running 20 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Tally of the one-cycle store, commit and discard pulses.
  always @(posedge core_clk)
  begin
    if (st === 1'b1) n_st <= n_st + 1;
    if (cm === 1'b1) n_cm <= n_cm + 1;
    if (dc === 1'b1) n_dc <= n_dc + 1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  function automatic logic [1:0] cls(input int h, input int w);
    return (h == 0) ? 2'h0 : (h == w) ? 2'h1 : 2'h2;
  endfunction : cls

  // Tolerates tick phase and the two-flop input delay.
  function automatic logic inr(input int v, input int e);
    return (v >= e - 10) && (v <= e + 15);
  endfunction : inr

  function automatic int ev(input int which);
    return (which == 0) ? n_st : (which == 1) ? n_cm : (which == 2) ? n_dc : int'(so1);
  endfunction : ev

  // Waits, bounded, for a pulse tally or the first output to change.
  task automatic wait_ev(input int which, input int lim);
    int base;
    base = ev(which);
    el = 0;
    while (ev(which) == base && el < lim)
    begin
      @(negedge core_clk);
      el++;
    end
  endtask : wait_ev

  // Counts lit cycles of each LED and red pulses over a window.
  task automatic watch(input int w);
    logic last;
    hg = 0;
    hy = 0;
    hr = 0;
    hs = 0;
    pr = 0;
    last = 1'b0;
    repeat (w)
    begin
      @(negedge core_clk);
      hg += int'(g === 1'b1);
      hy += int'(y === 1'b1);
      hr += int'(r === 1'b1);
      hs += int'(so1 === 1'b1 || so2 === 1'b1);
      if (r === 1'b1 && last !== 1'b1)
        pr++;
      last = r;
    end
  endtask : watch

  // Power cycle; outputs must be quiet while supply is off.
  task automatic power_cycle;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (10) @(posedge core_clk);
    check({so1, so2, g, y, r, st, cm, dc}, 8'h00);
    rstn <= 1'b1;
  endtask : power_cycle

  // A hang is cut short a little past the expected run of about 91k clocks.
  initial
  begin
    repeat (98000) @(posedge core_clk);
    miscompares++;
    summarize;
  end

  // Main sequence: table rows, then flash codes, teach-in and variants.
  initial
  begin
    rstn = 1'b0;
    {in_one, in_two, coded, onet, flt, pos, aid} = {4'hE, 6'h00, 2'h2, 4'h1};
    power_cycle;
    foreach (rows[i])
    begin
      @(posedge core_clk);
      coded <= rows[i].coded;
      pos <= rows[i].pos;
      aid <= rows[i].id;
      {in_one, in_two} <= rows[i].inp;
      flt <= rows[i].flt;
      cyc(8);
      check({so1, so2}, {2{rows[i].so}});
      watch(WIN);
      check({cls(hg, WIN), cls(hy, WIN), cls(hr, WIN)}, {rows[i].eg, rows[i].ey, rows[i].er});
      $display("row %0d done", i);
    end
    @(posedge core_clk);
    flt <= 6'h00;
    power_cycle;
    cyc(10);
    check({so1, so2}, 2'h3);
    @(posedge core_clk);
    pos <= 2'h0;
    cyc(3);
    check({so1, so2}, 2'h0);
    $display("prompt shutdown done");
    foreach (cmask[i])
    begin
      @(posedge core_clk);
      flt <= cmask[i];
      pos <= 2'h2;
      power_cycle;
      cyc(4);
      watch((cnum[i] + `ATSL_PAUSE_SLOTS) * `ATSL_PULSE_SLOT_MS * TK - 200);
      check(pr, cnum[i]);
      check({hs != 0, hg != 0, hy != 0}, 3'h0);
      $display("flash code %0d done", cnum[i]);
    end
    @(posedge core_clk);
    flt <= 6'h00;
    aid <= 4'h2;
    power_cycle;
    cyc(40);
    watch(WIN);
    check(hr, WIN);
    check({hs, cls(hy, WIN), hy >= 400 && hy <= 2000}, {32'h0, 2'h2, 1'b1});
    wait_ev(0, 1000);
    check(inr(40 + WIN + el, SETTLE * TK), 1'b1);
    watch(1400);
    check(hy > 0 && hy <= 500, 1'b1);
    wait_ev(2, 1000);
    check(inr(1400 + el, WAITP * TK), 1'b1);
    cyc(4);
    watch((5 + `ATSL_PAUSE_SLOTS) * `ATSL_PULSE_SLOT_MS * TK - 200);
    check(pr, 5);
    $display("teach abort done");
    power_cycle;
    wait_ev(0, 3000);
    check(el < 3000, 1'b1);
    @(posedge core_clk);
    pos <= 2'h0;
    power_cycle;
    wait_ev(1, 50);
    check(el, 50);
    @(posedge core_clk);
    pos <= 2'h2;
    wait_ev(1, 20);
    check(el < 20, 1'b1);
    cyc(8);
    watch(WIN);
    check({hs, cls(hg, WIN), cls(hy, WIN), cls(hr, WIN)}, {32'h0, 6'h20});
    wait_ev(3, 1000);
    check(inr(8 + WIN + el, INHIB * TK), 1'b1);
    cyc(4);
    check({g, so2}, 2'h3);
    $display("teach commit done");
    @(posedge core_clk);
    onet <= 1'b1;
    aid <= 4'h3;
    power_cycle;
    wait_ev(0, 3000);
    check({el, r, so1}, {32'd3000, 2'h0});
    $display("one-time lock done");
    summarize;
  end
endmodule : tb_top
`default_nettype wire
